/* File: logic/lc_pkg.sv */
// constants, field layouts and carrier types of the link control bank
package lc_pkg;

    // register byte addresses on the bus
    localparam logic [7:0] LC_LINK_CAP_ADDR  = 8'h7C;
    localparam logic [7:0] LC_LINK_CTRL_ADDR = 8'h80;
    localparam logic [7:0] LC_DIAG1_ADDR     = 8'hC4;
    localparam logic [7:0] LC_GEN_CTRL_ADDR  = 8'hD4;
    localparam logic [7:0] LC_PM_STAT_ADDR   = 8'hE0;

    // link control field positions
    localparam int LC_ASPM_LSB = 0;
    localparam int LC_RSVD_BIT = 2;
    localparam int LC_RCB_BIT  = 3;
    localparam int LC_LD_BIT   = 4;
    localparam int LC_RL_BIT   = 5;
    localparam int LC_CCC_BIT  = 6;
    localparam int LC_ES_BIT   = 7;
    localparam int LC_CPM_BIT  = 8;
    localparam int LC_HWAW_BIT = 9;

    // general control and diagnostic field positions
    localparam int LC_CPM_OVRD_BIT  = 23;
    localparam int LC_ASPM_OVRD_LSB = 28;
    localparam int LC_L1_COMMON_LSB = 18;
    localparam int LC_L1_ASYNC_LSB  = 15;

    // link capabilities field positions
    localparam int LC_CAP_PORT_LSB  = 24;
    localparam int LC_CAP_CLKPM_BIT = 18;
    localparam int LC_CAP_L1_LSB    = 15;
    localparam int LC_CAP_L0S_LSB   = 12;
    localparam int LC_CAP_ASPM_LSB  = 10;
    localparam int LC_CAP_WIDTH_LSB = 4;
    localparam int LC_CAP_SPEED_LSB = 0;

    // reset values and fixed codes
    localparam logic       LC_CPM_OVRD_RST  = 1'h0;
    localparam logic [1:0] LC_ASPM_OVRD_RST = 2'h0;
    localparam logic [2:0] LC_L1_COMMON_RST = 3'h3;
    localparam logic [2:0] LC_L1_ASYNC_RST  = 3'h4;
    localparam logic [2:0] LC_L0S_COMMON    = 3'h3;
    localparam logic [2:0] LC_L0S_ASYNC     = 3'h4;
    localparam logic [7:0] LC_PORT_NUM      = 8'h00;
    localparam logic [1:0] LC_ASPM_SUPPORT  = 2'h3;
    localparam logic [5:0] LC_MAX_WIDTH     = 6'h01;
    localparam logic [3:0] LC_MAX_SPEED     = 4'h1;
    localparam logic [1:0] LC_RESP_OK       = 2'h0;
    localparam logic [1:0] LC_RESP_SLVERR   = 2'h2;

    // active-state entry encodings
    localparam logic [1:0] LC_ASPM_OFF  = 2'h0;
    localparam logic [1:0] LC_ASPM_L0S  = 2'h1;
    localparam logic [1:0] LC_ASPM_L1   = 2'h2;
    localparam logic [1:0] LC_ASPM_BOTH = 2'h3;

    // writable link control fields
    typedef struct packed {
        logic       cpm;
        logic       es;
        logic       ccc;
        logic       rcb;
        logic [1:0] aspm;
    } lc_link_ctrl_s;

    // default-override bits of the general control register
    typedef struct packed {
        logic       cpm_ovrd;
        logic [1:0] aspm_ovrd;
    } lc_gen_ctrl_s;

    // exit latency codes of the diagnostic register
    typedef struct packed {
        logic [2:0] l1_common;
        logic [2:0] l1_async;
    } lc_diag_s;

    // bus slave states, one-hot
    typedef enum logic [1:0] {
        LC_BUS_IDLE = 2'b01,
        LC_BUS_ACK  = 2'b10
    } lc_bus_e;

endpackage

/* File: logic/lc_link_control.sv */
// link control register bank with its avalon slave and clock request pin
//
// Contract
// - the autonomous width disable bit reads zero and ignores writes.
// - with clock pm disabled the clock request pin is held low.
// - with clock pm enabled the pin may be released to stop the refclk.
// - clock pm enable resets to the general control override bit.
// - extended sync asks for long fts plus a ts2 on l1 exit, reset zero.
// - common clock config is read-write and picks the exit latencies.
// - common clock config resets to zero, the asynchronous clock case.
// - the retrain link bit always reads zero.
// - the link disable bit always reads zero.
// - read completion boundary is plain storage, 64 at reset.
// - the reserved bit below the completion boundary reads zero.
// - the two-bit active-state field gates l0s and l1 entry.
// - the active-state field resets to the general control override.
// - l1 exit latency comes from one of two diagnostic fields by ccc.
`timescale 1ns/100ps
`default_nettype none

module lc_link_control
    import lc_pkg::*;
(
    input  wire logic        clk,            // core clock, 100 MHz
    input  wire logic        rst,            // async reset, active high
    input  wire logic [7:0]  address,        // avalon byte address
    input  wire logic        read,           // avalon read request
    input  wire logic        write,          // avalon write request
    input  wire logic [31:0] writedata,      // avalon write data
    input  wire logic [3:0]  byteenable,     // avalon byte lanes
    output logic [31:0]      readdata,       // avalon read data
    output logic [1:0]       response,       // avalon response code
    output logic             waitrequest,    // avalon stall
    input  wire logic        link_l1_idle,   // link sits idle in l1
    input  wire logic        clkreq_n_in,    // clock request pin level
    output logic             clkreq_n_out,   // clock request pin drive
    output logic             clkreq_n_oe,    // clock request pin enable
    output logic             aspm_l0s_en,    // l0s entry allowed
    output logic             aspm_l1_en,     // l1 entry allowed
    output logic             extended_sync,  // long sync on l1 exit
    output logic             common_clock,   // shared refclk reported
    output logic             root_rcb_128,   // root boundary is 128
    output logic [2:0]       l1_exit_lat,    // reported l1 exit code
    output logic [2:0]       l0s_exit_lat    // reported l0s exit code
);

    // merge write data into a word under the byte enables
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // link control image, fixed bits forced to zero
    function automatic logic [31:0] pack_ctrl(input lc_link_ctrl_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[LC_ASPM_LSB +: 2] = c.aspm;
        w[LC_RCB_BIT]       = c.rcb;
        w[LC_CCC_BIT]       = c.ccc;
        w[LC_ES_BIT]        = c.es;
        w[LC_CPM_BIT]       = c.cpm;
        return w;
    endfunction

    lc_bus_e       state_reg, state_next;
    logic [31:0]   rdata_reg, rdata_next;
    logic [1:0]    resp_reg, resp_next;
    lc_link_ctrl_s ctrl_reg, ctrl_next;
    lc_gen_ctrl_s  gen_reg, gen_next;
    lc_diag_s      diag_reg, diag_next;
    logic          load_reg, load_next;
    logic          pin_meta_reg, pin_meta_next;
    logic          pin_sync_reg, pin_sync_next;
    logic          release_reg, release_next;
    logic [2:0]    l1lat_reg, l1lat_next;
    logic [2:0]    l0slat_reg, l0slat_next;
    logic          wr_go;
    logic [31:0]   wword;
    logic [31:0]   cap_word;
    logic [31:0]   gen_word;
    logic [31:0]   diag_word;
    logic [31:0]   stat_word;

    // a write lands only at the edge where waitrequest is low
    assign wr_go       = (state_reg == LC_BUS_ACK) && write;
    assign waitrequest = (state_reg != LC_BUS_ACK);
    assign readdata    = rdata_reg;
    assign response    = resp_reg;

    // read images of the surrounding registers
    always_comb begin
        cap_word = 32'h0000_0000;
        cap_word[LC_CAP_PORT_LSB +: 8]  = LC_PORT_NUM;
        cap_word[LC_CAP_CLKPM_BIT]      = 1'b1;
        cap_word[LC_CAP_L1_LSB +: 3]    = l1lat_reg;
        cap_word[LC_CAP_L0S_LSB +: 3]   = l0slat_reg;
        cap_word[LC_CAP_ASPM_LSB +: 2]  = LC_ASPM_SUPPORT;
        cap_word[LC_CAP_WIDTH_LSB +: 6] = LC_MAX_WIDTH;
        cap_word[LC_CAP_SPEED_LSB +: 4] = LC_MAX_SPEED;
        gen_word = 32'h0000_0000;
        gen_word[LC_CPM_OVRD_BIT]         = gen_reg.cpm_ovrd;
        gen_word[LC_ASPM_OVRD_LSB +: 2]   = gen_reg.aspm_ovrd;
        diag_word = 32'h0000_0000;
        diag_word[LC_L1_COMMON_LSB +: 3]  = diag_reg.l1_common;
        diag_word[LC_L1_ASYNC_LSB +: 3]   = diag_reg.l1_async;
        stat_word = {30'h0000_0000, release_reg, pin_sync_reg};
    end

    // bus slave: one wait cycle, data captured while stalled
    always_comb begin
        state_next = state_reg;
        rdata_next = rdata_reg;
        resp_next  = resp_reg;
        case (state_reg)
            LC_BUS_IDLE: begin
                // the override load must finish before any access
                if ((read || write) && !load_reg) begin
                    state_next = LC_BUS_ACK;
                    resp_next  = LC_RESP_OK;
                    rdata_next = 32'h0000_0000;
                    if (address == LC_LINK_CTRL_ADDR) begin
                        rdata_next = pack_ctrl(ctrl_reg);
                    end else if (address == LC_LINK_CAP_ADDR) begin
                        rdata_next = cap_word;
                    end else if (address == LC_DIAG1_ADDR) begin
                        rdata_next = diag_word;
                    end else if (address == LC_GEN_CTRL_ADDR) begin
                        rdata_next = gen_word;
                    end else if (address == LC_PM_STAT_ADDR) begin
                        rdata_next = stat_word;
                    end else begin
                        resp_next = LC_RESP_SLVERR;
                    end
                end
            end
            LC_BUS_ACK: begin
                state_next = LC_BUS_IDLE;
            end
            default: begin
                state_next = LC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= LC_BUS_IDLE;
            rdata_reg <= 32'h0000_0000;
            resp_reg  <= LC_RESP_OK;
        end else begin
            state_reg <= state_next;
            rdata_reg <= rdata_next;
            resp_reg  <= resp_next;
        end
    end

    // register contents; overrides load one edge after reset release
    always_comb begin
        ctrl_next = ctrl_reg;
        gen_next  = gen_reg;
        diag_next = diag_reg;
        load_next = 1'b0;
        wword     = 32'h0000_0000;
        if (load_reg) begin
            ctrl_next.cpm  = gen_reg.cpm_ovrd;
            ctrl_next.aspm = gen_reg.aspm_ovrd;
        end else if (wr_go) begin
            if (address == LC_LINK_CTRL_ADDR) begin
                wword = lane_merge(pack_ctrl(ctrl_reg), writedata,
                                   byteenable);
                ctrl_next.cpm  = wword[LC_CPM_BIT];
                ctrl_next.es   = wword[LC_ES_BIT];
                ctrl_next.ccc  = wword[LC_CCC_BIT];
                ctrl_next.rcb  = wword[LC_RCB_BIT];
                ctrl_next.aspm = wword[LC_ASPM_LSB +: 2];
            end else if (address == LC_GEN_CTRL_ADDR) begin
                wword = lane_merge(gen_word, writedata, byteenable);
                gen_next.cpm_ovrd  = wword[LC_CPM_OVRD_BIT];
                gen_next.aspm_ovrd = wword[LC_ASPM_OVRD_LSB +: 2];
            end else if (address == LC_DIAG1_ADDR) begin
                wword = lane_merge(diag_word, writedata, byteenable);
                diag_next.l1_common = wword[LC_L1_COMMON_LSB +: 3];
                diag_next.l1_async  = wword[LC_L1_ASYNC_LSB +: 3];
            end
        end
    end

    // es and ccc reset to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= '{cpm: 1'b0, es: 1'b0, ccc: 1'b0, rcb: 1'b0,
                          aspm: LC_ASPM_OFF};
            gen_reg  <= '{cpm_ovrd: LC_CPM_OVRD_RST,
                          aspm_ovrd: LC_ASPM_OVRD_RST};
            diag_reg <= '{l1_common: LC_L1_COMMON_RST,
                          l1_async: LC_L1_ASYNC_RST};
            load_reg <= 1'b1;
        end else begin
            ctrl_reg <= ctrl_next;
            gen_reg  <= gen_next;
            diag_reg <= diag_next;
            load_reg <= load_next;
        end
    end

    // pin side: synchroniser, release decision, latency codes
    always_comb begin
        pin_meta_next = clkreq_n_in;
        pin_sync_next = pin_meta_reg;
        // release only when enabled and idle in l1; the next
        // enable is used so a cleared enable grabs the pin at once
        release_next  = ctrl_next.cpm && link_l1_idle;
        if (ctrl_reg.ccc) begin
            l1lat_next  = diag_reg.l1_common;
            l0slat_next = LC_L0S_COMMON;
        end else begin
            l1lat_next  = diag_reg.l1_async;
            l0slat_next = LC_L0S_ASYNC;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            release_reg  <= 1'b0;
            l1lat_reg    <= LC_L1_ASYNC_RST;
            l0slat_reg   <= LC_L0S_ASYNC;
        end else begin
            pin_meta_reg <= pin_meta_next;
            pin_sync_reg <= pin_sync_next;
            release_reg  <= release_next;
            l1lat_reg    <= l1lat_next;
            l0slat_reg   <= l0slat_next;
        end
    end

    // open-drain style: pin driven low unless released
    // low while disabled
    assign clkreq_n_out = 1'b0;
    assign clkreq_n_oe  = ~release_reg;

    // entry gates from the active-state field
    assign aspm_l0s_en = (ctrl_reg.aspm == LC_ASPM_L0S) ||
                         (ctrl_reg.aspm == LC_ASPM_BOTH);
    assign aspm_l1_en  = (ctrl_reg.aspm == LC_ASPM_L1) ||
                         (ctrl_reg.aspm == LC_ASPM_BOTH);

    // long sync request to the link layer
    assign extended_sync = ctrl_reg.es;
    assign common_clock  = ctrl_reg.ccc;
    // boundary only reported, the bridge keeps its own fixed value
    assign root_rcb_128  = ctrl_reg.rcb;
    assign l1_exit_lat   = l1lat_reg;
    assign l0s_exit_lat  = l0slat_reg;

endmodule

`default_nettype wire

/* File: test/lc_link_control_properties.sv */
// port-level checks of the link control bank
`timescale 1ns/100ps
`default_nettype none

module lc_link_control_chk
    import lc_pkg::*;
(
    input wire logic        clk,           // core clock
    input wire logic        rst,           // async reset
    input wire logic [7:0]  address,       // bus address
    input wire logic        read,          // bus read
    input wire logic        write,         // bus write
    input wire logic [31:0] readdata,      // bus read data
    input wire logic        waitrequest,   // bus stall
    input wire logic        link_l1_idle,  // link idle in l1
    input wire logic        clkreq_n_out,  // pin drive value
    input wire logic        clkreq_n_oe,   // pin enable
    input wire logic        aspm_l0s_en,   // l0s allowed
    input wire logic        aspm_l1_en,    // l1 allowed
    input wire logic        extended_sync, // long sync
    input wire logic        common_clock,  // shared refclk
    input wire logic        root_rcb_128,  // root boundary
    input wire logic [2:0]  l0s_exit_lat   // l0s code
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // a control register read at its answering edge
    sequence s_ctrl_rd;
        read && !waitrequest && address == LC_LINK_CTRL_ADDR;
    endsequence
    // any request still stalled
    sequence s_req_wait;
        (read || write) && waitrequest;
    endsequence

    chk_ro_zero: assert property (s_ctrl_rd |->
        (readdata & 32'hFFFF_FE34) == 32'h0)
        else $error("read-only control bits not zero");
    chk_aspm_image: assert property (s_ctrl_rd |->
        readdata[1:0] == {aspm_l1_en, aspm_l0s_en})
        else $error("active-state enables differ from field");
    chk_ctrl_image: assert property (s_ctrl_rd |->
        readdata[7] == extended_sync && readdata[6] == common_clock
        && readdata[3] == root_rcb_128)
        else $error("control outputs differ from register");
    chk_pin_low: assert property (clkreq_n_out == 1'b0)
        else $error("clock request drives high");
    chk_cpm_hold: assert property (s_ctrl_rd ##0 !readdata[8]
        |=> clkreq_n_oe)
        else $error("pin released with clock pm off");
    chk_idle_hold: assert property (!link_l1_idle |=> clkreq_n_oe)
        else $error("pin released outside l1");
    chk_l0s_common: assert property (common_clock |=>
        l0s_exit_lat == LC_L0S_COMMON)
        else $error("l0s code wrong for common clock");
    chk_l0s_async: assert property (!common_clock |=>
        l0s_exit_lat == LC_L0S_ASYNC)
        else $error("l0s code wrong for separate clocks");
    chk_ack_once: assert property ((read || write) && !waitrequest
        |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_ack_bound: assert property (s_req_wait |-> ##[1:3] !waitrequest)
        else $error("request not answered in time");
endmodule

bind lc_link_control lc_link_control_chk i_lc_link_control_chk (
    .clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .link_l1_idle(link_l1_idle), .clkreq_n_out(clkreq_n_out),
    .clkreq_n_oe(clkreq_n_oe), .aspm_l0s_en(aspm_l0s_en),
    .aspm_l1_en(aspm_l1_en), .extended_sync(extended_sync),
    .common_clock(common_clock), .root_rcb_128(root_rcb_128),
    .l0s_exit_lat(l0s_exit_lat));

`default_nettype wire

/* File: test/lc_link_control_tb.sv */
// self-checking bench for the link control bank
`timescale 1ns/100ps
`default_nettype none

module lc_link_control_tb
    import lc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'hF;
    logic        link_l1_idle = 1'b0;
    wire         clkreq_n_in;
    logic [31:0] readdata, q;
    logic [1:0]  response, r;
    logic        waitrequest, clkreq_n_out, clkreq_n_oe;
    logic        aspm_l0s_en, aspm_l1_en, extended_sync;
    logic        common_clock, root_rcb_128;
    logic [2:0]  l1_exit_lat, l0s_exit_lat;
    int          errors = 0;
    int          check_count = 0;

    always #5 clk = ~clk;
    // pin has a pull-up, so it reads high once released
    assign clkreq_n_in = clkreq_n_oe ? clkreq_n_out : 1'b1;

    lc_link_control i_lc_link_control (
        .clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .response(response),
        .waitrequest(waitrequest), .link_l1_idle(link_l1_idle),
        .clkreq_n_in(clkreq_n_in), .clkreq_n_out(clkreq_n_out),
        .clkreq_n_oe(clkreq_n_oe), .aspm_l0s_en(aspm_l0s_en),
        .aspm_l1_en(aspm_l1_en), .extended_sync(extended_sync),
        .common_clock(common_clock), .root_rcb_128(root_rcb_128),
        .l1_exit_lat(l1_exit_lat), .l0s_exit_lat(l0s_exit_lat));

    task automatic print_verdict();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one access; sampling right after the edge sees pre-edge values,
    // so waitrequest and readdata are taken at the answering edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= !wr;
        // no cycle budget here: only the watchdog ends a stuck access
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        r = response;
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_reset();
        bus(1'b0, LC_LINK_CTRL_ADDR, 32'h0);
        check(q, {23'h0, LC_CPM_OVRD_RST, 6'h00, LC_ASPM_OVRD_RST},
              "ctrl reset");
        check({29'h0, l1_exit_lat}, {29'h0, LC_L1_ASYNC_RST}, "l1");
    endtask

    task automatic t_ro_bits();
        bus(1'b1, LC_LINK_CTRL_ADDR, 32'hFFFF_FFFF);
        bus(1'b0, LC_LINK_CTRL_ADDR, 32'h0);
        check(q, 32'h0000_01CB, "ro bits");
        check({29'h0, extended_sync, common_clock, root_rcb_128}, 32'h7,
              "ctrl outs");
        bus(1'b1, LC_LINK_CTRL_ADDR, 32'h0);
    endtask

    task automatic t_aspm();
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, LC_LINK_CTRL_ADDR, 32'(c));
            check({30'h0, aspm_l1_en, aspm_l0s_en}, 32'(c), "aspm");
        end
    endtask

    task automatic t_latency();
        bus(1'b1, LC_DIAG1_ADDR, 32'h0015_0000);
        bus(1'b1, LC_LINK_CTRL_ADDR, 32'h40);
        @(posedge clk);
        check({29'h0, l1_exit_lat}, 32'h5, "l1 common");
        check({29'h0, l0s_exit_lat}, 32'h3, "l0s common");
        bus(1'b0, LC_LINK_CAP_ADDR, 32'h0);
        check({29'h0, q[LC_CAP_L1_LSB +: 3]}, 32'h5, "cap l1");
        check({29'h0, q[LC_CAP_L0S_LSB +: 3]}, 32'h3, "cap l0s");
        bus(1'b1, LC_LINK_CTRL_ADDR, 32'h0);
        @(posedge clk);
        check({29'h0, l1_exit_lat}, 32'h2, "l1 async");
        check({29'h0, l0s_exit_lat}, 32'h4, "l0s async");
        bus(1'b0, LC_LINK_CAP_ADDR, 32'h0);
        check({29'h0, q[LC_CAP_L1_LSB +: 3]}, 32'h2, "cap l1");
        check({29'h0, q[LC_CAP_L0S_LSB +: 3]}, 32'h4, "cap l0s");
    endtask

    task automatic t_clkreq();
        link_l1_idle <= 1'b1;
        repeat (3) @(posedge clk);
        check({31'h0, clkreq_n_oe}, 32'h1, "pin held");
        bus(1'b1, LC_LINK_CTRL_ADDR, 32'h100);
        repeat (2) @(posedge clk);
        check({31'h0, clkreq_n_oe}, 32'h0, "pin released");
        bus(1'b0, LC_PM_STAT_ADDR, 32'h0);
        check({30'h0, q[1:0]}, 32'h3, "pin pulled up");
        bus(1'b1, LC_LINK_CTRL_ADDR, 32'h0);
        check({31'h0, clkreq_n_oe}, 32'h1, "pin held at once");
        repeat (2) @(posedge clk);
        check({31'h0, clkreq_n_oe}, 32'h1, "pin held again");
        bus(1'b0, LC_PM_STAT_ADDR, 32'h0);
        check({30'h0, q[1:0]}, 32'h0, "pin low seen");
        link_l1_idle <= 1'b0;
    endtask

    task automatic t_unmapped();
        bus(1'b1, 8'h10, 32'hFFFF_FFFF);
        bus(1'b0, 8'h10, 32'h0);
        check({30'h0, r}, {30'h0, LC_RESP_SLVERR}, "bad resp");
        bus(1'b0, LC_LINK_CTRL_ADDR, 32'h0);
        check(q, 32'h0, "ctrl untouched");
    endtask

    // only lane 0 lands: the clock pm enable in lane 1 keeps its value
    task automatic t_lanes();
        byteenable <= 4'h1;
        bus(1'b1, LC_LINK_CTRL_ADDR, 32'hFFFF_FFFF);
        byteenable <= 4'hF;
        bus(1'b0, LC_LINK_CTRL_ADDR, 32'h0);
        check(q, 32'h0000_00CB, "lane 0 only");
    endtask

    // the whole run is well under 400 cycles
    initial begin
        #50000;
        errors++;
        $display("ERROR %0t: watchdog expired", $time);
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_ro_bits();
        t_aspm();
        t_latency();
        t_clkreq();
        t_unmapped();
        t_lanes();
        print_verdict();
    end
endmodule

`default_nettype wire
